/* File: src/ecr_config_status.sv */
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "ecr_params.svh"
module ecr_config_status
	import ecr_pkg::*;
(
	input  wire logic        I_MCLK,
	input  wire logic        I_RST,
	input  wire logic        I_WB_CYC,
	input  wire logic        I_WB_STB,
	input  wire logic        I_WB_WE,
	input  wire logic [7:0]  I_WB_ADR,
	input  wire logic [3:0]  I_WB_SEL,
	input  wire logic [31:0] I_WB_DAT,
	output logic      [31:0] O_WB_DAT,
	output logic             O_WB_ACK,
	input  wire logic        I_MDIO_IN,
	output logic             O_MDC,
	input  wire logic        I_MGT_START,
	input  wire logic        I_COL,
	input  wire logic        I_CRS,
	input  wire logic        I_TX_BUSY,
	input  wire logic        I_RX_ACTIVE,
	input  wire logic        I_EV_UBR,
	input  wire logic        I_EV_COL,
	input  wire logic        I_EV_RLE,
	input  wire logic        I_EV_COMP,
	input  wire logic        I_EV_BEX,
	input  wire logic        I_EV_UND,
	input  wire logic        I_RX_DONE,
	input  wire logic [47:0] I_RX_DA,
	input  wire logic [13:0] I_RX_LEN,
	input  wire logic [15:0] I_RX_LENTYPE,
	input  wire logic        I_RX_FCS_BAD,
	input  wire logic        I_RX_PAUSE,
	input  wire logic        I_RX_BUF_DONE,
	input  wire logic        I_RX_BUF_WRAP,
	output logic             O_SPEED_100,
	output logic             O_TX_IGNORE_CS,
	output logic             O_RX_DURING_TX,
	output logic             O_RX_ACCEPT,
	output logic             O_RX_REJECT,
	output logic             O_FCS_ERR_COUNT,
	output logic             O_RX_STORE_FCS,
	output logic [1:0]       O_RX_OFFSET,
	output logic             O_RETRY_TEST,
	output logic             O_TX_PAUSE,
	output logic             O_TX_BAD_FCS,
	output logic             O_TX_ER,
	output logic             O_MGT_BUSY,
	output logic [31:0]      O_RBQP
);
////////////////////////////////////////////////////////////////////////////////
logic [31:0] cfg;
logic [63:0] hash;
logic [5:0]  tsr_flags;
logic [29:0] rbqp_base;
logic [29:0] rbqp_cur;
logic [1:0]  mdio_sync;
logic [1:0]  col_sync;
logic [1:0]  crs_sync;
ecr_mgt_t    mgt_state;
logic [5:0]  mgt_div;
logic [5:0]  mgt_bits;
logic        tx_pause;
////////////////////////////////////////////////////////////////////////////////
// Bus decode
wire         wb_req   = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
wire         wb_wr    = wb_req & I_WB_WE;
wire         wr_cfg   = wb_wr & (I_WB_ADR == `ECR_OFS_CFG);
wire         wr_tsr   = wb_wr & (I_WB_ADR == `ECR_OFS_TSR);
wire         wr_rbqp  = wb_wr & (I_WB_ADR == `ECR_OFS_RBQP);
wire         wr_hlo   = wb_wr & (I_WB_ADR == `ECR_OFS_HASHLO);
wire         wr_hhi   = wb_wr & (I_WB_ADR == `ECR_OFS_HASHHI);
wire  [31:0] bmask    = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}},
                         {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
wire  [31:0] wdat_cfg = (cfg & ~bmask) | (I_WB_DAT & bmask & `ECR_CFG_MASK);
wire  [31:0] rd_nsr   = {29'h0, O_MGT_BUSY, mdio_sync[1], 1'b0};
wire  [31:0] rd_tsr   = {25'h0, tsr_flags[5:4], tsr_flags[3], I_TX_BUSY,
                         tsr_flags[2:0]};
wire  [31:0] next_rd  =
	(I_WB_ADR == `ECR_OFS_CFG)    ? cfg :
	(I_WB_ADR == `ECR_OFS_NSR)    ? rd_nsr :
	(I_WB_ADR == `ECR_OFS_TSR)    ? rd_tsr :
	(I_WB_ADR == `ECR_OFS_RBQP)   ? {rbqp_cur, 2'b00} :
	(I_WB_ADR == `ECR_OFS_HASHLO) ? hash[31:0] :
	(I_WB_ADR == `ECR_OFS_HASHHI) ? hash[63:32] : 32'h0;
////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers
always_ff @(posedge I_MCLK or posedge I_RST) begin
	if (I_RST) begin
		mdio_sync <= 2'h0;
		col_sync  <= 2'h0;
		crs_sync  <= 2'h0;
	end else begin
		mdio_sync <= {mdio_sync[0], I_MDIO_IN};
		col_sync  <= {col_sync[0], I_COL};
		crs_sync  <= {crs_sync[0], I_CRS};
	end
end
////////////////////////////////////////////////////////////////////////////////
// Register writes; unmapped addresses still ack, read zero
always_ff @(posedge I_MCLK or posedge I_RST) begin
	if (I_RST) begin
		O_WB_ACK <= 1'b0;
		O_WB_DAT <= 32'h0;
		cfg      <= `ECR_CFG_RESET;
		hash     <= 64'h0;
	end else begin
		O_WB_ACK <= wb_req;
		O_WB_DAT <= wb_req ? next_rd : 32'h0;
		if (wr_cfg)
			cfg <= wdat_cfg;
		if (wr_hlo)
			hash[31:0] <= (hash[31:0] & ~bmask) | (I_WB_DAT & bmask);
		if (wr_hhi)
			hash[63:32] <= (hash[63:32] & ~bmask) | (I_WB_DAT & bmask);
	end
end
////////////////////////////////////////////////////////////////////////////////
// Transmit status: TRANSMIT_UNDERRUN_FLAG,COMP,BUFFERS_EXHAUSTED_FLAG go to bits 6..4, RETRY_LIMIT_FLAG,COL,USED_BIT_READ_FLAG to bits 2..0
// full duplex ignores collision pin
wire        col_pin = col_sync[1] & ~cfg[`ECR_B_FD];
wire  [5:0] tsr_set = {I_EV_UND, I_EV_COMP, I_EV_BEX,
                       I_EV_RLE, I_EV_COL | col_pin, I_EV_UBR};
wire  [5:0] tsr_clr = (wr_tsr & I_WB_SEL[0]) ?
                      {I_WB_DAT[6:4], I_WB_DAT[2:0]} : 6'h0;
always_ff @(posedge I_MCLK or posedge I_RST) begin
	if (I_RST)
		tsr_flags <= 6'h0;
	else
		tsr_flags <= (tsr_flags & ~tsr_clr) | tsr_set;
end
////////////////////////////////////////////////////////////////////////////////
// Receive queue pointer
logic [9:0] rbqp_cnt;
always_ff @(posedge I_MCLK or posedge I_RST) begin
	if (I_RST) begin
		rbqp_base <= 30'h0;
		rbqp_cur  <= 30'h0;
		rbqp_cnt  <= 10'h0;
	end else if (wr_rbqp) begin
		rbqp_base <= I_WB_DAT[31:2];
		rbqp_cur  <= I_WB_DAT[31:2];
		rbqp_cnt  <= 10'h0;
	end else if (I_RX_BUF_DONE) begin
		if (I_RX_BUF_WRAP || rbqp_cnt == `ECR_WRAP_COUNT) begin
			rbqp_cur <= rbqp_base;
			rbqp_cnt <= 10'h0;
		end else begin
			// Each descriptor is two words
			rbqp_cur <= rbqp_cur + 30'h2;
			rbqp_cnt <= rbqp_cnt + 10'h1;
		end
	end
end
////////////////////////////////////////////////////////////////////////////////
// Management clock; only runs during an operation
ecr_div_t   div_sel;
logic [5:0] half_cnt;
assign div_sel  = ecr_div_t'(cfg[`ECR_B_CLK +: 2]);
assign half_cnt = (div_sel == ECR_DIV8)  ? 6'h03 :
                  (div_sel == ECR_DIV16) ? 6'h07 :
                  (div_sel == ECR_DIV32) ? 6'h0f : 6'h1f;
always_ff @(posedge I_MCLK or posedge I_RST) begin
	if (I_RST) begin
		mgt_state  <= ECR_MGT_IDLE;
		mgt_div    <= 6'h0;
		mgt_bits   <= 6'h0;
		O_MDC      <= 1'b0;
		O_MGT_BUSY <= 1'b0;
	end else begin
		case (mgt_state)
		ECR_MGT_IDLE: begin
			O_MDC <= 1'b0;
			if (I_MGT_START) begin
				mgt_state  <= ECR_MGT_LOW;
				mgt_div    <= 6'h0;
				mgt_bits   <= 6'h0;
				O_MGT_BUSY <= 1'b1;
			end
		end
		ECR_MGT_LOW: begin
			mgt_div <= mgt_div + 6'h1;
			if (mgt_div == half_cnt) begin
				mgt_div   <= 6'h0;
				O_MDC     <= 1'b1;
				mgt_state <= ECR_MGT_HIGH;
			end
		end
		ECR_MGT_HIGH: begin
			mgt_div <= mgt_div + 6'h1;
			if (mgt_div == half_cnt) begin
				mgt_div  <= 6'h0;
				O_MDC    <= 1'b0;
				mgt_bits <= mgt_bits + 6'h1;
				if (mgt_bits == 6'(`ECR_MDC_BITS - 1)) begin
					mgt_state  <= ECR_MGT_IDLE;
					O_MGT_BUSY <= 1'b0;
				end else
					mgt_state <= ECR_MGT_LOW;
			end
		end
		default: mgt_state <= ECR_MGT_IDLE;
		endcase
	end
end
////////////////////////////////////////////////////////////////////////////////
// Receive frame filter
wire        da_bcast = &I_RX_DA;
wire        da_mcast = I_RX_DA[0];
wire  [5:0] da_hash;
genvar g;
generate
	for (g = 0; g < 6; g++) begin : g_hash
		assign da_hash[g] = ^(I_RX_DA & (48'h0410_4104_1041 << g));
	end
endgenerate
wire        hash_hit = hash[da_hash];
wire        hash_ok  = hash_hit & (da_mcast ? cfg[`ECR_B_MTI] :
                                              cfg[`ECR_B_UNI]);
wire        bc_ok    = ~(da_bcast & cfg[`ECR_B_NBC]);
wire [13:0] len_max  = cfg[`ECR_B_JUMBO] ? `ECR_LEN_JUMBO :
                       cfg[`ECR_B_BIG]   ? `ECR_LEN_LONG : `ECR_LEN_NORMAL;
wire        len_ok   = I_RX_LEN <= len_max;
wire        lf_bad   = cfg[`ECR_B_LENGTH_CHECK_EN] & (I_RX_LENTYPE < `ECR_TYPE_MIN) &
                       ({2'b00, I_RX_LEN} < I_RX_LENTYPE);
wire        fcs_ok   = ~I_RX_FCS_BAD | cfg[`ECR_B_IGNORE_RX_FCS];
wire        addr_ok  = cfg[`ECR_B_CAF] | (bc_ok & (da_bcast | hash_ok));
wire        accept   = addr_ok & len_ok & ~lf_bad & fcs_ok;
////////////////////////////////////////////////////////////////////////////////
// Registered control outputs
always_ff @(posedge I_MCLK or posedge I_RST) begin
	if (I_RST) begin
		O_SPEED_100     <= 1'b0;
		O_TX_IGNORE_CS  <= 1'b0;
		O_RX_DURING_TX  <= 1'b0;
		O_RX_ACCEPT     <= 1'b0;
		O_RX_REJECT     <= 1'b0;
		O_FCS_ERR_COUNT <= 1'b0;
		O_RX_STORE_FCS  <= 1'b1;
		O_RX_OFFSET     <= 2'h0;
		O_RETRY_TEST    <= 1'b0;
		tx_pause        <= 1'b0;
		O_TX_PAUSE      <= 1'b0;
		O_TX_BAD_FCS    <= 1'b0;
		O_TX_ER         <= 1'b0;
		O_RBQP          <= 32'h0;
	end else begin
		O_SPEED_100     <= cfg[`ECR_B_SPD];
		O_TX_IGNORE_CS  <= cfg[`ECR_B_FD];
		O_RX_DURING_TX  <= cfg[`ECR_B_FD] | cfg[`ECR_B_HALF_DUPLEX_RX_WHILE_TX];
		O_RX_ACCEPT     <= I_RX_DONE & accept;
		O_RX_REJECT     <= I_RX_DONE & ~accept;
		O_FCS_ERR_COUNT <= I_RX_DONE & I_RX_FCS_BAD & ~cfg[`ECR_B_IGNORE_RX_FCS];
		O_RX_STORE_FCS  <= ~cfg[`ECR_B_DISCARD_RX_FCS];
		O_RX_OFFSET     <= cfg[`ECR_B_RX_BUFFER_OFFSET +: 2];
		O_RETRY_TEST    <= cfg[`ECR_B_RTY];
		if (I_RX_PAUSE & I_RX_DONE & accept & cfg[`ECR_B_PAE])
			tx_pause <= 1'b1;
		else if (~cfg[`ECR_B_PAE] | I_TX_BUSY & ~I_RX_ACTIVE)
			tx_pause <= tx_pause & cfg[`ECR_B_PAE] & ~I_TX_BUSY;
		O_TX_PAUSE      <= tx_pause;
		O_TX_BAD_FCS    <= I_EV_BEX | I_EV_UND;
		O_TX_ER         <= I_EV_BEX;
		O_RBQP          <= {rbqp_cur, 2'b00};
	end
end
endmodule // ecr_config_status

/* File: src/ecr_params.svh */
// Summary of operation
// - Speed bit set means 100 Mbit/s, clear means 10 Mbit/s.
// - Full duplex ignores collision and carrier sense; receive allowed during transmit.
// - Copy-all setting accepts every valid frame whatever its destination.
// - Jumbo setting accepts frames up to 10240 bytes.
// - Broadcast reject setting refuses all-ones destination frames unless copy-all is set.
// - Hash settings accept frames whose 6-bit hash hits a set table bit.
// - Frames above 1518 bytes rejected; long frame setting allows 1536.
// - Two-bit divider: management clock is system clock over 8, 16, 32, 64.
// - Management clock toggles only during operations; software keeps it under 2.5MHz.
// - Retry test: backoff one slot, pause counter decrements every receive clock.
// - Pause enable: a valid pause frame suspends transmission.
// - Two-bit offset shifts received data 0 to 3 bytes into first buffer.
// - Length check discards short frames; type 0600 and above never length error.
// - Discard FCS setting keeps the received FCS out of memory.
// - A bit allows half-duplex reception while transmitting.
// - Ignore FCS keeps CRC-error frames and counts no FCS error.
// - Status shows live management data pin and a management busy bit.
// - Transmit flags set by events, cleared by writing one, never set by write.
// - Buffers exhausted mid-frame: stop, bad FCS, transmit error, set flag.
// - Late fetch, bus error or mid-frame used bit sets underrun, forces bad CRC.
// - Receive queue pointer loads start, reads current, wraps at 1024 or wrap bit.
`ifndef ECR_PARAMS_SVH
`define ECR_PARAMS_SVH
`define ECR_OFS_CFG     8'h04
`define ECR_OFS_NSR     8'h08
`define ECR_OFS_TSR     8'h14
`define ECR_OFS_RBQP    8'h18
`define ECR_OFS_HASHLO  8'h90
`define ECR_OFS_HASHHI  8'h94
`define ECR_CFG_RESET   32'h0000_0800
`define ECR_CFG_MASK    32'h000f_fdfb
`define ECR_B_SPD       0
`define ECR_B_FD        1
`define ECR_B_JUMBO     3
`define ECR_B_CAF       4
`define ECR_B_NBC       5
`define ECR_B_MTI       6
`define ECR_B_UNI       7
`define ECR_B_BIG       8
`define ECR_B_CLK       10
`define ECR_B_RTY       12
`define ECR_B_PAE       13
`define ECR_B_RX_BUFFER_OFFSET      14
`define ECR_B_LENGTH_CHECK_EN      16
`define ECR_B_DISCARD_RX_FCS     17
`define ECR_B_HALF_DUPLEX_RX_WHILE_TX     18
`define ECR_B_IGNORE_RX_FCS    19
`define ECR_LEN_NORMAL  14'd1518
`define ECR_LEN_LONG    14'd1536
`define ECR_LEN_JUMBO   14'd10240
`define ECR_TYPE_MIN    16'h0600
`define ECR_WRAP_COUNT  10'h3ff
`define ECR_MDC_BITS    32
`endif

/* File: src/ecr_pkg.sv */
package ecr_pkg;
	typedef enum logic [1:0] {
		ECR_MGT_IDLE = 2'b00,
		ECR_MGT_LOW  = 2'b01,
		ECR_MGT_HIGH = 2'b10
	} ecr_mgt_t;
	typedef enum logic [1:0] {
		ECR_DIV8  = 2'b00,
		ECR_DIV16 = 2'b01,
		ECR_DIV32 = 2'b10,
		ECR_DIV64 = 2'b11
	} ecr_div_t;
endpackage

/* File: test/ecr_config_status_sva.sv */
`timescale 1ns/1ps
module ecr_config_status_sva (
	input wire logic        I_MCLK,
	input wire logic        I_RST,
	input wire logic        I_WB_CYC,
	input wire logic        I_WB_STB,
	input wire logic        O_WB_ACK,
	input wire logic [31:0] O_WB_DAT,
	input wire logic        O_MDC,
	input wire logic        O_MGT_BUSY,
	input wire logic        I_MGT_START,
	input wire logic        I_EV_BEX,
	input wire logic        I_EV_UND,
	input wire logic        O_TX_BAD_FCS,
	input wire logic        O_TX_ER,
	input wire logic        I_RX_DONE,
	input wire logic        I_RX_FCS_BAD,
	input wire logic        O_RX_ACCEPT,
	input wire logic        O_RX_REJECT,
	input wire logic        O_FCS_ERR_COUNT
);
default clocking @(posedge I_MCLK); endclocking
default disable iff (I_RST);
sequence s_req;
	I_WB_CYC && I_WB_STB && !O_WB_ACK;
endsequence
sequence s_ack;
	O_WB_ACK ##1 !O_WB_ACK;
endsequence
////////////////////////////////////////
a_ack_pulse: assert property (s_req |=> s_ack)
	else $error("ack not a single pulse after request");
a_rdat_zero: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0)
	else $error("read data not zero outside ack");
a_mdc_idle: assert property (
	!O_MGT_BUSY && !$past(O_MGT_BUSY) |-> $stable(O_MDC))
	else $error("management clock moved while idle");
a_busy_start: assert property (
	I_MGT_START && !O_MGT_BUSY |=> O_MGT_BUSY)
	else $error("busy not raised by start");
a_bex_stops: assert property (
	I_EV_BEX |=> O_TX_BAD_FCS && O_TX_ER)
	else $error("exhausted buffers without bad fcs and tx error");
a_er_cause: assert property (O_TX_ER |-> $past(I_EV_BEX))
	else $error("tx error without exhausted buffers");
a_und_crc: assert property (I_EV_UND |=> O_TX_BAD_FCS)
	else $error("underrun without bad crc");
a_fcs_count: assert property (
	O_FCS_ERR_COUNT |-> $past(I_RX_DONE && I_RX_FCS_BAD))
	else $error("fcs count without bad frame");
a_accept_one: assert property (
	O_RX_ACCEPT |-> $past(I_RX_DONE) && !O_RX_REJECT)
	else $error("accept without frame end or with reject");
endmodule // ecr_config_status_sva

/* File: test/ecr_phy_model.sv */
`timescale 1ns/1ps
module ecr_phy_model (
	input  wire logic i_clk,
	input  wire logic i_mdc,
	input  wire logic i_col_req,
	output logic      o_mdio,
	output logic      o_col,
	output logic      o_crs
);
// data only moves while clocked; pull-up holds it high otherwise
always_ff @(posedge i_clk) begin
	o_mdio <= i_mdc ? ~o_mdio : 1'b1;
	o_col <= i_col_req;
	o_crs <= i_col_req;
end
endmodule // ecr_phy_model

/* File: test/tb_ecr_config_status.sv */
`timescale 1ns/1ps
module tb_ecr_config_status import ecr_pkg::*;;
logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, start = 0, txb = 0;
logic rxa = 0, done = 0, bad = 0, pse = 0, bdone = 0, bwrap = 0, colq = 0;
logic [7:0] adr = 8'h00;
logic [3:0] sel = 4'hf;
logic [5:0] ev = 6'h00;
logic [31:0] wdat = 32'h0, rd, odat, rbq;
logic [47:0] da = 48'h0;
logic [13:0] len = 14'h0;
logic [15:0] lt = 16'h0;
logic [1:0] ofs;
logic ack, mdc, mdio, col, crs, speed_select, ign, rdt, acc, fcnt, sfcs, rtst;
logic pau, bfcs, ter, busy, rej;
int mismatches = 0, check_count = 0;
always #25 clk = ~clk;
ecr_config_status ecr_config_status_i (.I_MCLK(clk), .I_RST(rst),
	.I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
	.I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(odat), .O_WB_ACK(ack),
	.I_MDIO_IN(mdio), .O_MDC(mdc), .I_MGT_START(start), .I_COL(col),
	.I_CRS(crs), .I_TX_BUSY(txb), .I_RX_ACTIVE(rxa), .I_EV_UBR(ev[0]),
	.I_EV_COL(ev[1]), .I_EV_RLE(ev[2]), .I_EV_COMP(ev[3]),
	.I_EV_BEX(ev[4]), .I_EV_UND(ev[5]), .I_RX_DONE(done), .I_RX_DA(da),
	.I_RX_LEN(len), .I_RX_LENTYPE(lt), .I_RX_FCS_BAD(bad),
	.I_RX_PAUSE(pse), .I_RX_BUF_DONE(bdone), .I_RX_BUF_WRAP(bwrap),
	.O_SPEED_100(speed_select), .O_TX_IGNORE_CS(ign), .O_RX_DURING_TX(rdt),
	.O_RX_ACCEPT(acc), .O_RX_REJECT(rej), .O_FCS_ERR_COUNT(fcnt),
	.O_RX_STORE_FCS(sfcs), .O_RX_OFFSET(ofs), .O_RETRY_TEST(rtst),
	.O_TX_PAUSE(pau), .O_TX_BAD_FCS(bfcs), .O_TX_ER(ter),
	.O_MGT_BUSY(busy), .O_RBQP(rbq));
ecr_phy_model ecr_phy_model_i (.i_clk(clk), .i_mdc(mdc),
	.i_col_req(colq), .o_mdio(mdio), .o_col(col), .o_crs(crs));
////////////////////////////////////////
task automatic chk(input logic [31:0] g, input logic [31:0] e);
	check_count++;
	if (g !== e) begin
		mismatches++;
		$display("MISMATCH %0t got %h expected %h", $time, g, e);
	end
endtask
// Holds the request until ack is sampled; the wait is not counted on
task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
	@(posedge clk);
	cyc <= 1'b1;
	stb <= 1'b1;
	we <= w;
	adr <= a;
	wdat <= d;
	do @(posedge clk); while (ack !== 1'b1);
	rd = odat;
	cyc <= 1'b0;
	stb <= 1'b0;
endtask
task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
	wb(1'b0, a, 32'h0);
	chk(rd, e);
endtask
task automatic frame(input logic [31:0] cfg, input logic [47:0] d,
	input logic [13:0] l, input logic [15:0] t, input logic b,
	input logic [1:0] e);
	wb(1'b1, 8'h04, cfg);
	@(posedge clk);
	done <= 1'b1;
	da <= d;
	len <= l;
	lt <= t;
	bad <= b;
	@(posedge clk) done <= 1'b0;
	@(posedge clk);
	chk({acc, fcnt}, e);
	chk(rej, !e[1]);
endtask
task automatic bufs(input int n, input logic w);
	@(posedge clk);
	bdone <= 1'b1;
	bwrap <= w;
	repeat (n) @(posedge clk);
	bdone <= 1'b0;
	bwrap <= 1'b0;
endtask
////////////////////////////////////////
task automatic t_regs;
	rdchk(8'h04, 32'h0000_0800);
	rdchk(8'h08, 32'h0000_0002);
	rdchk(8'h14, 32'h0);
	rdchk(8'h18, 32'h0);
	rdchk(8'h40, 32'h0);
	wb(1'b1, 8'h08, 32'hffff_ffff);
	rdchk(8'h08, 32'h0000_0002);
	wb(1'b1, 8'h04, 32'hffff_ffff);
	rdchk(8'h04, 32'h000f_fdfb);
	$display("t_regs done");
endtask
task automatic t_cfg;
	for (int i = 0; i < 4; i++) begin
		wb(1'b1, 8'h04, 32'h0002_1803 | (i << 14));
		@(posedge clk);
		chk(ofs, i);
	end
	chk({speed_select, ign, rdt, rtst, sfcs}, 5'b11110);
	wb(1'b1, 8'h04, 32'h0004_0800);
	@(posedge clk);
	chk({speed_select, ign, rdt, sfcs}, 4'b0011);
	$display("t_cfg done");
endtask
task automatic t_mdc;
	int p;
	for (int c = 0; c < 4; c++) begin
		wb(1'b1, 8'h04, 32'(c) << 10);
		@(posedge clk) start <= 1'b1;
		@(posedge clk) start <= 1'b0;
		wb(1'b0, 8'h08, 32'h0);
		chk(rd & 32'h4, 32'h4);
		while (mdc !== 1'b0) @(posedge clk);
		while (mdc !== 1'b1) @(posedge clk);
		p = 0;
		while (mdc !== 1'b0) begin
			@(posedge clk);
			p++;
		end
		while (mdc !== 1'b1) begin
			@(posedge clk);
			p++;
		end
		chk(p, 8 << c);
		while (busy !== 1'b0) @(posedge clk);
		// Data pin returns to its pull-up level through the synchroniser
		repeat (4) @(posedge clk);
		rdchk(8'h08, 32'h0000_0002);
	end
	$display("t_mdc done");
endtask
task automatic t_tsr;
	@(posedge clk) txb <= 1'b1;
	ev <= 6'h3f;
	@(posedge clk) ev <= 6'h00;
	@(posedge clk);
	chk({bfcs, ter}, 2'b11);
	rdchk(8'h14, 32'h7f);
	wb(1'b1, 8'h14, 32'h01);
	rdchk(8'h14, 32'h7e);
	txb <= 1'b0;
	wb(1'b1, 8'h14, 32'hff);
	rdchk(8'h14, 32'h0);
	@(posedge clk) colq <= 1'b1;
	@(posedge clk) colq <= 1'b0;
	repeat (4) @(posedge clk);
	rdchk(8'h14, 32'h02);
	$display("t_tsr done");
endtask
task automatic t_rx;
	frame(32'h810, 48'h2, 14'd1518, 16'h0800, 1'b0, 2'b10);
	frame(32'h810, 48'h2, 14'd1519, 16'h0800, 1'b0, 2'b00);
	frame(32'h910, 48'h2, 14'd1536, 16'h0800, 1'b0, 2'b10);
	frame(32'h910, 48'h2, 14'd1537, 16'h0800, 1'b0, 2'b00);
	frame(32'h818, 48'h2, 14'd10240, 16'h0800, 1'b0, 2'b10);
	frame(32'h818, 48'h2, 14'd10241, 16'h0800, 1'b0, 2'b00);
	frame(32'h800, '1, 14'd64, 16'h0800, 1'b0, 2'b10);
	frame(32'h820, '1, 14'd64, 16'h0800, 1'b0, 2'b00);
	wb(1'b1, 8'h90, 32'h2);
	frame(32'h840, 48'h1, 14'd64, 16'h0800, 1'b0, 2'b10);
	wb(1'b1, 8'h90, 32'h0);
	frame(32'h840, 48'h1, 14'd64, 16'h0800, 1'b0, 2'b00);
	frame(32'h10810, 48'h2, 14'd60, 16'd50, 1'b0, 2'b10);
	frame(32'h10810, 48'h2, 14'd60, 16'd200, 1'b0, 2'b00);
	frame(32'h10810, 48'h2, 14'd60, 16'h0600, 1'b0, 2'b10);
	frame(32'h810, 48'h2, 14'd64, 16'h0800, 1'b1, 2'b01);
	frame(32'h80810, 48'h2, 14'd64, 16'h0800, 1'b1, 2'b10);
	pse <= 1'b1;
	frame(32'h2810, 48'h2, 14'd64, 16'h0800, 1'b0, 2'b10);
	pse <= 1'b0;
	@(posedge clk);
	chk(pau, 1'b1);
	$display("t_rx done");
endtask
task automatic t_rbqp;
	wb(1'b1, 8'h18, 32'h0000_1000);
	bufs(1024, 1'b0);
	rdchk(8'h18, 32'h0000_1000);
	bufs(2, 1'b0);
	rdchk(8'h18, 32'h0000_1010);
	bufs(1, 1'b1);
	rdchk(8'h18, 32'h0000_1000);
	chk(rbq, 32'h0000_1000);
	$display("t_rbqp done");
endtask
task automatic give_verdict;
	$display("checks %0d mismatches %0d", check_count, mismatches);
	if (mismatches == 0 && check_count > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask
initial begin
	repeat (4) @(posedge clk);
	rst <= 1'b0;
	t_regs;
	t_cfg;
	t_mdc;
	t_tsr;
	t_rx;
	t_rbqp;
	give_verdict;
end
// Longest test is the slowest divider sweep, well inside this span
initial begin
	repeat (20000) @(posedge clk);
	mismatches++;
	give_verdict;
end
endmodule // tb_ecr_config_status
bind ecr_config_status ecr_config_status_sva ecr_config_status_sva_i (
	.I_MCLK(I_MCLK), .I_RST(I_RST), .I_WB_CYC(I_WB_CYC),
	.I_WB_STB(I_WB_STB), .O_WB_ACK(O_WB_ACK), .O_WB_DAT(O_WB_DAT),
	.O_MDC(O_MDC), .O_MGT_BUSY(O_MGT_BUSY), .I_MGT_START(I_MGT_START),
	.I_EV_BEX(I_EV_BEX), .I_EV_UND(I_EV_UND), .O_TX_BAD_FCS(O_TX_BAD_FCS),
	.O_TX_ER(O_TX_ER), .I_RX_DONE(I_RX_DONE), .I_RX_FCS_BAD(I_RX_FCS_BAD),
	.O_RX_ACCEPT(O_RX_ACCEPT), .O_RX_REJECT(O_RX_REJECT),
	.O_FCS_ERR_COUNT(O_FCS_ERR_COUNT));
